// ===== cpr_defs.vh
// Constants for the core power control register block.
// Assumes inclusion by its bare name from the design files of this block.
`ifndef CPR_DEFS_VH
`define CPR_DEFS_VH

// Register width and reset value.
`define CPR_REG_W 64
`define CPR_REG_RESET 64'h0000000000000000

// Field positions.
`define CPR_EVT_DLY_HI 9
`define CPR_EVT_DLY_LO 7
`define CPR_INT_DLY_HI 6
`define CPR_INT_DLY_LO 4
`define CPR_PWRDN_BIT 0

// Bits that hold state; all others read as zero.
`define CPR_WRITE_MASK 64'h00000000000003F1

// Access decode.
`define CPR_OP0 2'h3
`define CPR_OP1 3'h0
`define CPR_CRN 4'hF
`define CPR_CRM 4'h2
`define CPR_OP2 3'h7

// Privilege levels.
`define CPR_LVL_USER 2'h0
`define CPR_LVL_KERNEL 2'h1
`define CPR_LVL_HYP 2'h2
`define CPR_LVL_MON 2'h3

// Trap syndrome class.
`define CPR_SYNDROME 6'h18

// Retention delays in system counter ticks per code.
`define CPR_TICKS_1 10'h002
`define CPR_TICKS_2 10'h008
`define CPR_TICKS_3 10'h020
`define CPR_TICKS_4 10'h040
`define CPR_TICKS_5 10'h080
`define CPR_TICKS_6 10'h100
`define CPR_TICKS_7 10'h200
`define CPR_TICK_CNT_W 10

`endif

// ===== cpr_ret_timer.v
// Retention delay timer counting system counter ticks during a wait state.
// Assumes tick_i is a one-cycle pulse on clk_sys_i and active_i a same-clock level.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_defs.vh"

module cpr_ret_timer (
   // Clock and reset.
   input wire clk_sys_i,
   input wire rst_n_i,
   // Control.
   input wire active_i,
   input wire [2:0] code_i,
   input wire tick_i,
   // Status.
   output reg expired_o
);

   reg [`CPR_TICK_CNT_W-1:0] count_q;
   reg [`CPR_TICK_CNT_W-1:0] count_d;
   wire [`CPR_TICK_CNT_W-1:0] target;

   // Maps a delay code to the number of ticks it requires.
   function [`CPR_TICK_CNT_W-1:0] ticks_for;
      input [2:0] code;
      begin
         case (code)
            3'h1: ticks_for = `CPR_TICKS_1;
            3'h2: ticks_for = `CPR_TICKS_2;
            3'h3: ticks_for = `CPR_TICKS_3;
            3'h4: ticks_for = `CPR_TICKS_4;
            3'h5: ticks_for = `CPR_TICKS_5;
            3'h6: ticks_for = `CPR_TICKS_6;
            3'h7: ticks_for = `CPR_TICKS_7;
            default: ticks_for = {`CPR_TICK_CNT_W{1'b0}};
         endcase
      end
   endfunction

   assign target = ticks_for(code_i);

   // Counts ticks only while waiting; leaving the wait state clears the count.
   always @* begin
      count_d = count_q;
      if (!active_i || code_i == 3'h0) begin
         count_d = {`CPR_TICK_CNT_W{1'b0}}; // [R12] [R02] [R03]
      end else if (tick_i && count_q < target) begin
         count_d = count_q + 10'h001; // [R04]
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q <= {`CPR_TICK_CNT_W{1'b0}};
         expired_o <= 1'b0;
      end else begin
         count_q <= count_d;
         expired_o <= active_i && code_i != 3'h0 && count_d >= target; // [R04]
      end
   end

endmodule // cpr_ret_timer

`default_nettype wire

// ===== cpr_core_power_ctrl.v
// Core power control register with access checks and dynamic retention timing.
// Assumes access requests, wait-state levels and trap controls come from core logic on clk_sys_i;
// the system counter tick level comes from another domain.
//
// Contract
// R01 - 64-bit register, all bits reset to zero.
// R02 - Event-wait delay field bits 9:7, zero disables.
// R03 - Interrupt-wait delay field bits 6:4, zero disables.
// R04 - Delay counts system ticks, then retention entered.
// R05 - Bit 0 requests power down on wait.
// R06 - User level access is undefined.
// R07 - Kernel access traps to hypervisor if trap bit.
// R08 - Write traps to hypervisor without its enable.
// R09 - Else write traps to monitor without enable.
// R10 - Hyp/monitor reads return; monitor writes always.
// R11 - Decode op0 3, op1 0, CRn 15, CRm 2, op2 7.
// R12 - Count restarts per wait; early wake abandons.
// R13 - Reserved bits read zero, ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_defs.vh"

module cpr_core_power_ctrl (
   // Clock and reset.
   input wire clk_sys_i,
   input wire rst_n_i,
   // System register access request.
   input wire sr_req_i,
   input wire sr_write_i,
   input wire [1:0] sr_op0_i,
   input wire [2:0] sr_op1_i,
   input wire [3:0] sr_crn_i,
   input wire [3:0] sr_crm_i,
   input wire [2:0] sr_op2_i,
   input wire [1:0] sr_level_i,
   input wire [63:0] sr_wdata_i,
   // Trap controls held elsewhere in the core.
   input wire hyp_enabled_i,
   input wire impl_register_trap_i,
   input wire hyp_power_register_write_enable_i,
   input wire mon_power_register_write_enable_i,
   // Access answer.
   output reg sr_ack_o,
   output reg sr_hit_o,
   output reg [63:0] sr_rdata_o,
   output reg sr_undef_o,
   output reg sr_trap_o,
   output reg [1:0] sr_trap_level_o,
   output reg [5:0] sr_syndrome_o,
   // Wait state and system counter.
   input wire wait_for_event_i,
   input wire wait_for_interrupt_i,
   input wire sys_tick_level_i,
   // Power controller side.
   output reg core_powerdown_request_o,
   output reg retention_request_o,
   output reg [63:0] core_power_control_o
);

   reg [63:0] ctrl_q;
   reg tick_meta_q;
   reg tick_sync_q;
   reg tick_prev_q;
   reg in_wait_q;
   reg kind_q;
   wire tick_pulse;
   wire decode_hit;
   wire in_wait;
   wire new_entry;
   wire timer_active;
   wire [2:0] sel_code;
   wire timer_expired;
   reg undef_d;
   reg trap_d;
   reg [1:0] trap_level_d;
   reg do_write_d;

   // Recognises the access encoding of this register.
   function match_encoding;
      input [1:0] op0;
      input [2:0] op1;
      input [3:0] crn;
      input [3:0] crm;
      input [2:0] op2;
      begin
         match_encoding = op0 == `CPR_OP0 && op1 == `CPR_OP1 && crn == `CPR_CRN &&
                          crm == `CPR_CRM && op2 == `CPR_OP2;
      end
   endfunction

   assign decode_hit = sr_req_i && match_encoding(sr_op0_i, sr_op1_i, sr_crn_i, sr_crm_i, sr_op2_i); // [R11]

   // Privilege checks in priority order.
   always @* begin
      undef_d = 1'b0;
      trap_d = 1'b0;
      trap_level_d = `CPR_LVL_USER;
      do_write_d = 1'b0;
      case (sr_level_i)
         `CPR_LVL_USER: begin
            undef_d = 1'b1; // [R06]
         end
         `CPR_LVL_KERNEL: begin
            if (hyp_enabled_i && impl_register_trap_i) begin
               trap_d = 1'b1; // [R07]
               trap_level_d = `CPR_LVL_HYP;
            end else if (sr_write_i && hyp_enabled_i && !hyp_power_register_write_enable_i) begin
               trap_d = 1'b1; // [R08]
               trap_level_d = `CPR_LVL_HYP;
            end else if (sr_write_i && !mon_power_register_write_enable_i) begin
               trap_d = 1'b1; // [R09]
               trap_level_d = `CPR_LVL_MON;
            end else begin
               do_write_d = sr_write_i;
            end
         end
         `CPR_LVL_HYP: begin
            if (sr_write_i && hyp_enabled_i && !hyp_power_register_write_enable_i) begin
               trap_d = 1'b1; // [R08]
               trap_level_d = `CPR_LVL_HYP;
            end else if (sr_write_i && !mon_power_register_write_enable_i) begin
               trap_d = 1'b1; // [R09]
               trap_level_d = `CPR_LVL_MON;
            end else begin
               do_write_d = sr_write_i; // [R10]
            end
         end
         `CPR_LVL_MON: begin
            do_write_d = sr_write_i; // [R10]
         end
         default: begin
            undef_d = 1'b1;
         end
      endcase
   end

   // Register storage and access answer.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= `CPR_REG_RESET; // [R01]
         sr_ack_o <= 1'b0;
         sr_hit_o <= 1'b0;
         sr_rdata_o <= 64'h0000000000000000;
         sr_undef_o <= 1'b0;
         sr_trap_o <= 1'b0;
         sr_trap_level_o <= 2'h0;
         sr_syndrome_o <= 6'h00;
      end else begin
         sr_ack_o <= sr_req_i;
         sr_hit_o <= decode_hit;
         sr_undef_o <= decode_hit && undef_d;
         sr_trap_o <= decode_hit && trap_d;
         sr_trap_level_o <= (decode_hit && trap_d) ? trap_level_d : 2'h0;
         sr_syndrome_o <= (decode_hit && trap_d) ? `CPR_SYNDROME : 6'h00;
         if (decode_hit && !sr_write_i && !undef_d && !trap_d) begin
            sr_rdata_o <= ctrl_q; // [R10]
         end else begin
            sr_rdata_o <= 64'h0000000000000000;
         end
         if (decode_hit && do_write_d) begin
            ctrl_q <= sr_wdata_i & `CPR_WRITE_MASK; // [R13]
         end
      end
   end

   // System counter tick crossing and edge detect.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_meta_q <= 1'b0;
         tick_sync_q <= 1'b0;
         tick_prev_q <= 1'b0;
      end else begin
         tick_meta_q <= sys_tick_level_i;
         tick_sync_q <= tick_meta_q;
         tick_prev_q <= tick_sync_q;
      end
   end

   assign tick_pulse = tick_sync_q && !tick_prev_q; // [R04]

   // Wait-state tracking; a new entry or a change of wait kind restarts the count.
   assign in_wait = wait_for_event_i || wait_for_interrupt_i;
   assign new_entry = in_wait && (!in_wait_q || kind_q != wait_for_interrupt_i); // [R12]
   assign timer_active = in_wait && !new_entry;
   assign sel_code = wait_for_interrupt_i ? ctrl_q[`CPR_INT_DLY_HI:`CPR_INT_DLY_LO] // [R03]
                                          : ctrl_q[`CPR_EVT_DLY_HI:`CPR_EVT_DLY_LO]; // [R02]

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_wait_q <= 1'b0;
         kind_q <= 1'b0;
      end else begin
         in_wait_q <= in_wait;
         kind_q <= wait_for_interrupt_i;
      end
   end

   cpr_ret_timer u_ret_timer (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .active_i(timer_active),
      .code_i(sel_code),
      .tick_i(tick_pulse),
      .expired_o(timer_expired)
   );

   // Power controller outputs.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_powerdown_request_o <= 1'b0;
         retention_request_o <= 1'b0;
         core_power_control_o <= `CPR_REG_RESET;
      end else begin
         core_powerdown_request_o <= ctrl_q[`CPR_PWRDN_BIT]; // [R05]
         retention_request_o <= timer_expired && in_wait; // [R04] [R12]
         core_power_control_o <= ctrl_q;
      end
   end

endmodule // cpr_core_power_ctrl

`default_nettype wire

// ===== cpr_core_power_ctrl_properties.sv
// Checker for the core power control block.
// Assumes it is bound to cpr_core_power_ctrl.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_defs.vh"
module cpr_chk (
   // Clock, reset, request, trap controls and wait state.
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic sr_req_i,
   input wire logic sr_write_i,
   input wire logic [1:0] sr_op0_i,
   input wire logic [2:0] sr_op1_i,
   input wire logic [3:0] sr_crn_i,
   input wire logic [3:0] sr_crm_i,
   input wire logic [2:0] sr_op2_i,
   input wire logic [1:0] sr_level_i,
   input wire logic [63:0] sr_wdata_i,
   input wire logic hyp_enabled_i,
   input wire logic impl_register_trap_i,
   input wire logic wait_for_event_i,
   input wire logic wait_for_interrupt_i,
   // Answer and power side.
   input wire logic sr_ack_o,
   input wire logic sr_hit_o,
   input wire logic [63:0] sr_rdata_o,
   input wire logic sr_undef_o,
   input wire logic sr_trap_o,
   input wire logic [1:0] sr_trap_level_o,
   input wire logic [5:0] sr_syndrome_o,
   input wire logic core_powerdown_request_o,
   input wire logic retention_request_o,
   input wire logic [63:0] core_power_control_o
);
   wire hit = sr_req_i && {sr_op0_i, sr_op1_i, sr_crn_i, sr_crm_i, sr_op2_i} ==
      {`CPR_OP0, `CPR_OP1, `CPR_CRN, `CPR_CRM, `CPR_OP2};
   wire lv_k = sr_level_i == `CPR_LVL_KERNEL;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_ack; sr_req_i |=> sr_ack_o && sr_hit_o == $past(hit); endproperty
   a_ack: assert property (p_ack) else $error("ack or hit wrong");
   property p_idle; !sr_req_i |=> !sr_ack_o; endproperty
   a_idle: assert property (p_idle) else $error("ack without request");
   property p_miss; sr_req_i && !hit |=> !sr_undef_o && !sr_trap_o && sr_rdata_o == 0; endproperty
   a_miss: assert property (p_miss) else $error("miss had effect");
   property p_user; hit && sr_level_i == `CPR_LVL_USER |=> sr_undef_o && !sr_trap_o && sr_rdata_o == 0; endproperty
   a_user: assert property (p_user) else $error("user access not undefined");
   property p_impl; hit && lv_k && hyp_enabled_i && impl_register_trap_i |=>
      sr_trap_o && sr_trap_level_o == `CPR_LVL_HYP && sr_syndrome_o == `CPR_SYNDROME; endproperty
   a_impl: assert property (p_impl) else $error("impl trap wrong");
   property p_mon; hit && sr_write_i && sr_level_i == `CPR_LVL_MON |=> !sr_trap_o ##1
      core_power_control_o == ($past(sr_wdata_i, 2) & `CPR_WRITE_MASK); endproperty
   a_mon: assert property (p_mon) else $error("monitor write lost");
   property p_resv; core_power_control_o[63:10] == 0 && core_power_control_o[3:1] == 0; endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
   property p_pd; core_powerdown_request_o == core_power_control_o[0]; endproperty
   a_pd: assert property (p_pd) else $error("powerdown request mismatch");
   property p_wake; (!wait_for_event_i && !wait_for_interrupt_i) [*3] |-> !retention_request_o; endproperty
   a_wake: assert property (p_wake) else $error("retention outside wait");
endmodule // cpr_chk
bind cpr_core_power_ctrl cpr_chk cpr_chk_i (.*);
`default_nettype wire

// ===== cpr_tick_model.sv
// System counter model giving a tick level to the block.
// Assumes en_i is raised while the core waits.
`timescale 1ns/1ps
`default_nettype none
module cpr_tick_model (
   // Clock and control.
   input wire logic clk_sys_i,
   input wire logic en_i,
   // Tick level.
   output var logic tick_o
);
   logic [1:0] cnt_q;
   initial cnt_q = 2'h0;
   initial tick_o = 1'b0;
   // Each level stands four cycles, one tick every eight.
   always @(posedge clk_sys_i) begin
      if (en_i) begin
         cnt_q <= cnt_q + 2'h1;
         if (cnt_q == 2'h3) tick_o <= ~tick_o;
      end
   end
endmodule // cpr_tick_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the core power control block.
// Assumes the tick model drives the system counter level.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_defs.vh"
module testbench;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, req = 1'b0, wr = 1'b0, he = 1'b0, it = 1'b0;
   logic hw = 1'b0, mw = 1'b0, wait_for_event = 1'b0, wait_for_interrupt = 1'b0, ten = 1'b0, tick, ack, hit, und, trp, pd, ret;
   logic [1:0] lv = 2'h0, tl;
   logic [5:0] syn;
   logic [15:0] enc = {`CPR_OP0, `CPR_OP1, `CPR_CRN, `CPR_CRM, `CPR_OP2};
   logic [63:0] wd = 64'h0, rd, cpc;
   int bad_count = 0, checks_done = 0, cyc = 0;
   always #2.5 clk_sys_i = ~clk_sys_i;
   cpr_tick_model cpr_tick_model_i (.clk_sys_i(clk_sys_i), .en_i(ten), .tick_o(tick));
   cpr_core_power_ctrl cpr_core_power_ctrl_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .sr_req_i(req), .sr_write_i(wr), .sr_op0_i(enc[15:14]), .sr_op1_i(enc[13:11]),
      .sr_crn_i(enc[10:7]), .sr_crm_i(enc[6:3]), .sr_op2_i(enc[2:0]), .sr_level_i(lv),
      .sr_wdata_i(wd), .hyp_enabled_i(he), .impl_register_trap_i(it),
      .hyp_power_register_write_enable_i(hw), .mon_power_register_write_enable_i(mw),
      .sr_ack_o(ack), .sr_hit_o(hit), .sr_rdata_o(rd), .sr_undef_o(und), .sr_trap_o(trp),
      .sr_trap_level_o(tl), .sr_syndrome_o(syn), .wait_for_event_i(wait_for_event),
      .wait_for_interrupt_i(wait_for_interrupt), .sys_tick_level_i(tick), .core_powerdown_request_o(pd),
      .retention_request_o(ret), .core_power_control_o(cpc));
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string n, input logic [63:0] s, input logic [63:0] e);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // One access from a falling edge; the strobe stays low for a cycle between accesses.
   task acc(input logic w, input logic [1:0] l, input logic [63:0] d);
      @(negedge clk_sys_i);
      wr = w;
      lv = l;
      wd = d;
      req = 1'b1;
      @(negedge clk_sys_i);
      req = 1'b0;
   endtask
   task ans(input logic [11:0] e, input logic [63:0] r);
      chk("answer", {52'h0, ack, hit, und, trp, tl, syn}, {52'h0, e});
      chk("rdata", rd, r);
   endtask
   task cyc_n(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task wret(input int n);
      repeat (n) if (ret !== 1'b1) @(negedge clk_sys_i);
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         stop_test;
      end
   end
   initial begin
      cyc_n(16);
      rst_n_i = 1'b1;
      cyc_n(1);
      acc(0, 2'h3, 64'h0); ans(12'hC00, 64'h0);
      acc(1, 2'h3, 64'hFFFFFFFFFFFFFFFF); ans(12'hC00, 64'h0);
      cyc_n(1);
      chk("ctrl", cpc, `CPR_WRITE_MASK);
      chk("pwrdn", {63'h0, pd}, 64'h1);
      acc(0, 2'h2, 64'h0); ans(12'hC00, `CPR_WRITE_MASK);
      $display("register test done");
      acc(0, 2'h0, 64'h0); ans(12'hE00, 64'h0);
      he = 1'b1;
      it = 1'b1;
      acc(0, 2'h1, 64'h0); ans({4'hD, `CPR_LVL_HYP, `CPR_SYNDROME}, 64'h0);
      it = 1'b0;
      acc(1, 2'h1, 64'h10); ans({4'hD, `CPR_LVL_HYP, `CPR_SYNDROME}, 64'h0);
      acc(1, 2'h2, 64'h10); ans({4'hD, `CPR_LVL_HYP, `CPR_SYNDROME}, 64'h0);
      hw = 1'b1;
      acc(1, 2'h1, 64'h10); ans({4'hD, `CPR_LVL_MON, `CPR_SYNDROME}, 64'h0);
      acc(1, 2'h2, 64'h10); ans({4'hD, `CPR_LVL_MON, `CPR_SYNDROME}, 64'h0);
      mw = 1'b1;
      acc(1, 2'h1, 64'h10); ans(12'hC00, 64'h0);
      enc[0] = 1'b0;
      acc(0, 2'h3, 64'h0); ans(12'h800, 64'h0);
      enc[0] = 1'b1;
      acc(0, 2'h1, 64'h0); ans(12'hC00, 64'h10);
      $display("access test done");
      wait_for_interrupt = 1'b1;
      ten = 1'b1;
      cyc_n(4);
      chk("early", {63'h0, ret}, 64'h0);
      wret(60);
      chk("ret_int", {63'h0, ret}, 64'h1);
      wait_for_interrupt = 1'b0;
      cyc_n(3);
      chk("wake", {63'h0, ret}, 64'h0);
      acc(1, 2'h3, 64'h100);
      wait_for_event = 1'b1;
      cyc_n(40);
      wait_for_event = 1'b0;
      cyc_n(3);
      wait_for_event = 1'b1;
      cyc_n(40);
      chk("restart", {63'h0, ret}, 64'h0);
      wret(100);
      chk("ret_evt", {63'h0, ret}, 64'h1);
      wait_for_event = 1'b0;
      acc(1, 2'h3, 64'h1);
      wait_for_interrupt = 1'b1;
      cyc_n(150);
      chk("off", {63'h0, ret}, 64'h0);
      $display("retention test done");
      wait_for_interrupt = 1'b0;
      rst_n_i = 1'b0;
      cyc_n(2);
      chk("reset_ctrl", cpc, 64'h0);
      chk("reset_pwrdn", {63'h0, pd}, 64'h0);
      rst_n_i = 1'b1;
      cyc_n(1);
      acc(0, 2'h3, 64'h0); ans(12'hC00, 64'h0);
      $display("reset test done");
      stop_test;
   end
endmodule // testbench
`default_nettype wire
